//--- isar_pkg.sv
package isar_pkg;

  // ----------------------------------------------------------------
  // Slave mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_7B        = 4'h6;
  localparam logic [3:0] MODE_10B       = 4'h7;
  localparam logic [3:0] MODE_7B_SS     = 4'he;
  localparam logic [3:0] MODE_10B_SS    = 4'hf;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam int         OWN_HI_MSB     = 2;
  localparam int         OWN_HI_LSB     = 1;

  // ----------------------------------------------------------------
  // Framing and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_DATA_CNT  = 4'h7;
  localparam logic [3:0] ACK_SLOT_CNT   = 4'h8;
  localparam logic [7:0] OWN_ADDR_RST   = 8'h00;
  localparam logic [7:0] BUF_RST        = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ADDR    = 2'b01,
    ST_ADDR_LO = 2'b10,
    ST_DATA    = 2'b11
  } isar_state_t;

endpackage : isar_pkg

//--- isar_slave_rx.sv
`timescale 1ns/10ps
// Overview of operation
// R1: Start/stop irq enables raise irq only in modes lacking start/stop irq.
// R2: Ninth pulse is acknowledge slot; receiver pulls data low to accept.
// R3: Data level sampled in acknowledge slot goes to received-ack status.
// R4: With hold enables set, software's ack value select drives the slot.
// R5: With both hold enables clear, hardware acknowledges matches and bytes.
// R6: Buffer full or overflow set when a byte arrives gives not-acknowledge.
// R7: Once addressed, ack-phase flag sets after eighth fall, hold modes only.
// R8: Four slave modes: 7-bit or 10-bit, with or without start/stop irq.
// R9: Modes with start/stop irq set irq on start, restart and stop.
// R10: First byte after start compared to own address; match loads, irqs.
// R11: Address mismatch returns to idle silently, no flags set.
// R12: 7-bit mode ignores the direction bit when matching.
// R13: 10-bit high byte matches 11110, own bits 2:1, then zero.
// R14: After high byte ack, set pending flag, hold clock until address write.
// R15: Low byte compares all eight bits; irq, pending flag, hold regardless.
// R16: Own address write clears the pending flag.
// R17: 10-bit read needs prior full write match before high byte ack.
// R18: Matching write address clears direction, loads buffer, acknowledges.
// R19: Irq flag sets per transferred byte; only software clears it.
// R20: Stretch enable holds clock after each received byte until release.
// R21: Start condition sets start-detected status.
// R22: Stop condition sets stop-detected status, bus becomes idle.
// R23: Reading the data buffer clears the buffer-full flag.
// R24: Bytes shift most significant bit first, then one acknowledge bit.
// R25: Data sampled on rising clock; changes with clock high are start/stop.
// R26: Transfer of a received byte into the buffer sets buffer-full.
// R27: Byte completing with buffer full sets overflow, buffer kept.
module isar_slave_rx (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       scl_clk_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oen_o,
  output logic            sda_o,
  output logic            sda_oen_o,
  input  wire logic [3:0] port_mode_select_i,
  input  wire logic       start_irq_enable_i,
  input  wire logic       stop_irq_enable_i,
  input  wire logic       address_hold_enable_i,
  input  wire logic       data_hold_enable_i,
  input  wire logic       stretch_enable_i,
  input  wire logic       ack_value_select_i,
  input  wire logic       clock_release_set_i,
  input  wire logic [7:0] own_address_wdata_i,
  input  wire logic       own_address_we_i,
  input  wire logic       irq_clear_i,
  input  wire logic       buffer_read_i,
  input  wire logic       overflow_clear_i,
  output logic [7:0]      rx_tx_buffer_o,
  output logic [7:0]      own_address_reg_o,
  output logic            serial_port_irq_flag_o,
  output logic            buffer_full_flag_o,
  output logic            receive_overflow_flag_o,
  output logic            received_ack_flag_o,
  output logic            ack_phase_flag_o,
  output logic            low_byte_pending_flag_o,
  output logic            read_dir_flag_o,
  output logic            start_seen_flag_o,
  output logic            stop_seen_flag_o,
  output logic            clock_release_bit_o
);

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  // R8: four slave modes
  function automatic logic mode_on(input logic [3:0] m);
    mode_on = (m == isar_pkg::MODE_7B) || (m == isar_pkg::MODE_10B) ||
              (m == isar_pkg::MODE_7B_SS) || (m == isar_pkg::MODE_10B_SS);
  endfunction : mode_on

  function automatic logic mode_ten(input logic [3:0] m);
    mode_ten = (m == isar_pkg::MODE_10B) || (m == isar_pkg::MODE_10B_SS);
  endfunction : mode_ten

  function automatic logic mode_ss(input logic [3:0] m);
    mode_ss = (m == isar_pkg::MODE_7B_SS) || (m == isar_pkg::MODE_10B_SS);
  endfunction : mode_ss

  // ----------------------------------------------------------------
  // Link side: shifting on the bus clock
  // ----------------------------------------------------------------
  logic       link_clr_r;
  logic       link_rst_n;
  logic       bit_smp_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] byte_r;
  logic       ack_bit_r;
  logic       byte_tgl_r;
  logic       ack_tgl_r;

  // Held in reset while the bus is idle or a start is in flight
  assign link_rst_n = nrst_i & ~link_clr_r;

  // R25: sample on rise
  always_ff @(posedge scl_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_smp_r <= 1'b0;
    end else begin
      bit_smp_r <= sda_i;
    end
  end

  // R24: msb first, ninth is ack
  always_ff @(negedge scl_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
    end else if (bit_cnt_r == isar_pkg::ACK_SLOT_CNT) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= {shift_r[6:0], bit_smp_r};
    end
  end

  // Byte and ack events toward the system side
  always_ff @(negedge scl_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      byte_r     <= 8'h00;
      ack_bit_r  <= 1'b1;
      byte_tgl_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
    end else if (link_rst_n) begin
      if (bit_cnt_r == isar_pkg::LAST_DATA_CNT) begin
        byte_r     <= {shift_r[6:0], bit_smp_r};
        byte_tgl_r <= ~byte_tgl_r;
      end
      // R2: ninth pulse ends ack slot
      if (bit_cnt_r == isar_pkg::ACK_SLOT_CNT) begin
        ack_bit_r <= bit_smp_r;
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic [2:0] byte_s_r;
  logic [2:0] ack_s_r;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s_r  <= 3'h7;
      sda_s_r  <= 3'h7;
      byte_s_r <= 3'h0;
      ack_s_r  <= 3'h0;
    end else begin
      scl_s_r  <= {scl_s_r[1:0], scl_clk_i};
      sda_s_r  <= {sda_s_r[1:0], sda_i};
      byte_s_r <= {byte_s_r[1:0], byte_tgl_r};
      ack_s_r  <= {ack_s_r[1:0], ack_tgl_r};
    end
  end

  logic start_evt;
  logic stop_evt;
  logic byte_evt;
  logic ack_evt;

  // R25: data edges while clock high
  assign start_evt = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
  assign stop_evt  = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];
  assign byte_evt  = byte_s_r[1] ^ byte_s_r[2];
  assign ack_evt   = ack_s_r[1] ^ ack_s_r[2];

  // Link reset: raised at start or stop, dropped once the clock is low
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_clr_r <= 1'b1;
    end else if (start_evt || stop_evt) begin
      link_clr_r <= 1'b1;
    end else if (!scl_s_r[1]) begin
      link_clr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte decision
  // ----------------------------------------------------------------
  isar_pkg::isar_state_t st_r;
  logic [7:0] own_addr_r;
  logic [7:0] buf_r;
  logic       bf_r;
  logic       ov_r;
  logic       prior_match_r;
  logic       on;
  logic       ten;
  logic       addr7_hit;
  logic       hi_hit;
  logic       lo_hit;
  logic       hit;
  logic       take;
  logic       ovf;
  logic       hw_ack;
  logic       hold;

  assign on  = mode_on(port_mode_select_i);
  assign ten = mode_ten(port_mode_select_i);
  assign ovf = bf_r | ov_r;

  // R12: direction bit ignored
  assign addr7_hit = byte_r[7:1] == own_addr_r[7:1];
  // R13: high byte pattern
  assign hi_hit = (byte_r[7:3] == isar_pkg::TEN_BIT_PREFIX) &&
                  (byte_r[2:1] ==
                   own_addr_r[isar_pkg::OWN_HI_MSB:isar_pkg::OWN_HI_LSB]);
  // R15: all eight bits
  assign lo_hit = byte_r == own_addr_r;

  always_comb begin
    case (st_r)
      // R10: first byte after start; R17: read needs prior match
      isar_pkg::ST_ADDR:    hit = ten ? hi_hit & (~byte_r[0] | prior_match_r)
                                      : addr7_hit;
      isar_pkg::ST_ADDR_LO: hit = 1'b1;
      isar_pkg::ST_DATA:    hit = 1'b1;
      default:              hit = 1'b0;
    endcase
  end

  assign take   = byte_evt & on & hit;
  // R5, R6: hardware ack unless buffer full, overflow or low byte miss
  assign hw_ack = ~ovf & ((st_r != isar_pkg::ST_ADDR_LO) | lo_hit);
  assign hold   = (st_r == isar_pkg::ST_DATA) ? data_hold_enable_i
                                              : address_hold_enable_i;

  // ----------------------------------------------------------------
  // Slave state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r          <= isar_pkg::ST_IDLE;
      prior_match_r <= 1'b0;
    end else if (!on || stop_evt) begin
      // R22: stop idles the bus
      st_r          <= isar_pkg::ST_IDLE;
      prior_match_r <= 1'b0;
    end else if (start_evt) begin
      st_r <= isar_pkg::ST_ADDR;
    end else if (byte_evt) begin
      case (st_r)
        isar_pkg::ST_ADDR: begin
          if (!hit) begin
            // R11: silent mismatch
            st_r          <= isar_pkg::ST_IDLE;
            prior_match_r <= 1'b0;
          end else if (byte_r[0]) begin
            st_r <= isar_pkg::ST_IDLE;
          end else if (ten) begin
            st_r          <= isar_pkg::ST_ADDR_LO;
            prior_match_r <= 1'b0;
          end else begin
            st_r <= isar_pkg::ST_DATA;
          end
        end
        isar_pkg::ST_ADDR_LO: begin
          st_r          <= lo_hit ? isar_pkg::ST_DATA : isar_pkg::ST_IDLE;
          prior_match_r <= lo_hit;
        end
        default: st_r <= st_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data buffer, full and overflow flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_r <= isar_pkg::BUF_RST;
      bf_r  <= 1'b0;
      ov_r  <= 1'b0;
    end else begin
      // R23: read clears full
      if (buffer_read_i) begin
        bf_r <= 1'b0;
      end
      if (overflow_clear_i) begin
        ov_r <= 1'b0;
      end
      if (take && bf_r) begin
        // R27: overflow, buffer kept
        ov_r <= 1'b1;
      end else if (take && hw_ack) begin
        // R26: transfer sets full; R18: address loaded
        buf_r <= byte_r;
        bf_r  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge and clock hold
  // ----------------------------------------------------------------
  logic ckp_r;
  logic ua_r;
  logic ack_wait_r;
  logic ack_ok_r;
  logic ack_drv_r;
  logic pend_ten_r;
  logic rw_r;
  logic sda_oen_r;
  logic scl_oen_r;
  logic drive_lo_r;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_oen_r  <= 1'b1;
      ack_wait_r <= 1'b0;
      ack_ok_r   <= 1'b0;
      ack_drv_r  <= 1'b0;
    end else if (ack_evt || start_evt || stop_evt) begin
      sda_oen_r  <= 1'b1;
      ack_wait_r <= 1'b0;
    end else if (take) begin
      ack_ok_r   <= hw_ack;
      ack_wait_r <= hold;
      // R4: wait for software value; R5: hardware ack now
      sda_oen_r  <= hold | ~hw_ack;
      ack_drv_r  <= ~hold & hw_ack;
    end else if (byte_evt) begin
      ack_drv_r <= 1'b0;
    end else if (ack_wait_r && clock_release_set_i) begin
      // R4: software chosen ack; R6 still refuses
      sda_oen_r  <= ack_value_select_i | ~ack_ok_r;
      ack_drv_r  <= ~ack_value_select_i & ack_ok_r;
      ack_wait_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ckp_r <= 1'b1;
    end else if (take && hold) begin
      // R7: stretch at eighth fall in hold modes
      ckp_r <= 1'b0;
    end else if (ack_evt && stretch_enable_i && ack_drv_r && !rw_r) begin
      // R20: stretch after received byte
      ckp_r <= 1'b0;
    end else if (clock_release_set_i || !on) begin
      ckp_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_ten_r <= 1'b0;
    end else if (start_evt || stop_evt) begin
      pend_ten_r <= 1'b0;
    end else if (take) begin
      pend_ten_r <= ten & ((st_r == isar_pkg::ST_ADDR_LO) |
                           ((st_r == isar_pkg::ST_ADDR) & ~byte_r[0]));
    end else if (ack_evt) begin
      pend_ten_r <= 1'b0;
    end
  end

  // Own address and its pending flag
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      own_addr_r <= isar_pkg::OWN_ADDR_RST;
      ua_r       <= 1'b0;
    end else begin
      if (own_address_we_i) begin
        own_addr_r <= own_address_wdata_i;
        // R16: write clears pending
        ua_r       <= 1'b0;
      end
      // R14, R15: pending and hold after the 10-bit high write byte and the low byte
      if (ack_evt && pend_ten_r) begin
        ua_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_oen_r  <= 1'b1;
      drive_lo_r <= 1'b0;
    end else begin
      // R14: clock low until address rewritten
      scl_oen_r  <= ckp_r & ~ua_r;
      drive_lo_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flag and status
  // ----------------------------------------------------------------
  logic irq_r;
  logic received_ack_flag_r;
  logic ack_phase_flag_r;
  logic start_r;
  logic stop_r;
  logic ss_irq;

  // R1, R9: start/stop irq in ss modes or when enabled
  assign ss_irq = on & ((start_evt & (mode_ss(port_mode_select_i) |
                                      start_irq_enable_i)) |
                        (stop_evt & (mode_ss(port_mode_select_i) |
                                     stop_irq_enable_i)));

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r <= 1'b0;
    end else if (ss_irq || (take && hold) ||
                 (ack_evt && (ack_drv_r || pend_ten_r))) begin
      // R19: per byte, set wins; R10: match irq; R15: even on miss
      irq_r <= 1'b1;
    end else if (irq_clear_i) begin
      irq_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      received_ack_flag_r <= 1'b0;
      ack_phase_flag_r  <= 1'b0;
      start_r   <= 1'b0;
      stop_r    <= 1'b0;
      rw_r      <= 1'b0;
    end else begin
      // R3: sampled ack level
      if (ack_evt) begin
        received_ack_flag_r <= ack_bit_r;
        ack_phase_flag_r  <= 1'b0;
      end else if (take && (address_hold_enable_i || data_hold_enable_i)) begin
        // R7: ack phase flag
        ack_phase_flag_r <= 1'b1;
      end
      // R21: start seen
      if (start_evt) begin
        start_r <= 1'b1;
        stop_r  <= 1'b0;
      end else if (stop_evt) begin
        // R22: stop seen
        stop_r  <= 1'b1;
        start_r <= 1'b0;
      end
      // R18: direction from matched address
      if (take && st_r == isar_pkg::ST_ADDR) begin
        rw_r <= byte_r[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign scl_o                   = drive_lo_r;
  assign sda_o                   = drive_lo_r;
  assign scl_oen_o               = scl_oen_r;
  assign sda_oen_o               = sda_oen_r;
  assign rx_tx_buffer_o          = buf_r;
  assign own_address_reg_o       = own_addr_r;
  assign serial_port_irq_flag_o  = irq_r;
  assign buffer_full_flag_o      = bf_r;
  assign receive_overflow_flag_o = ov_r;
  assign received_ack_flag_o     = received_ack_flag_r;
  assign ack_phase_flag_o        = ack_phase_flag_r;
  assign low_byte_pending_flag_o = ua_r;
  assign read_dir_flag_o         = rw_r;
  assign start_seen_flag_o       = start_r;
  assign stop_seen_flag_o        = stop_r;
  assign clock_release_bit_o     = ckp_r;

endmodule : isar_slave_rx

//--- isar_sva_chk_asserts.sv
`timescale 1ns/10ps
module isar_sva_chk (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl_clk_i,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oen_o,
  input wire logic sda_oen_o,
  input wire logic address_hold_enable_i,
  input wire logic data_hold_enable_i,
  input wire logic own_address_we_i,
  input wire logic irq_clear_i,
  input wire logic buffer_read_i,
  input wire logic overflow_clear_i,
  input wire logic clock_release_set_i,
  input wire logic serial_port_irq_flag_o,
  input wire logic buffer_full_flag_o,
  input wire logic receive_overflow_flag_o,
  input wire logic ack_phase_flag_o,
  input wire logic low_byte_pending_flag_o,
  input wire logic clock_release_bit_o
);
  // ------
  // Port checks
  // ------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  property p_low_only; !scl_o && !sda_o; endproperty
  a_low_only: assert property (p_low_only) else $error("line high");
  property p_ack_edge; $changed(sda_oen_o) |-> !scl_clk_i; endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("sda moved");
  property p_no_ack_ovf;
    $fell(sda_oen_o) |-> !receive_overflow_flag_o;
  endproperty
  a_no_ack_ovf: assert property (p_no_ack_ovf) else $error("ack on ovf");
  property p_stretch;
    $fell(scl_oen_o) |-> !clock_release_bit_o || low_byte_pending_flag_o;
  endproperty
  a_stretch: assert property (p_stretch) else $error("bad hold");
  property p_release;
    clock_release_set_i && !scl_oen_o && !low_byte_pending_flag_o
      |=> ##1 scl_oen_o;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_ack_phase;
    $rose(ack_phase_flag_o) |-> address_hold_enable_i || data_hold_enable_i;
  endproperty
  a_ack_phase: assert property (p_ack_phase) else $error("ack phase");
  property p_irq_keep;
    $fell(serial_port_irq_flag_o) |-> $past(irq_clear_i);
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
  property p_full_clr; buffer_read_i && scl_clk_i |=> !buffer_full_flag_o;
  endproperty
  a_full_clr: assert property (p_full_clr) else $error("full kept");
  property p_ovf_keep;
    $fell(receive_overflow_flag_o) |-> $past(overflow_clear_i);
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("ovf lost");
  property p_pend_clr; own_address_we_i |=> !low_byte_pending_flag_o;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending");

  c_ack: cover property ($fell(sda_oen_o));
  c_pend: cover property ($rose(low_byte_pending_flag_o));
  c_hold: cover property ($rose(ack_phase_flag_o));
endmodule : isar_sva_chk

bind isar_slave_rx isar_sva_chk chk_u (
  .clk_sys_i, .nrst_i, .scl_clk_i, .scl_o, .sda_o, .scl_oen_o,
  .sda_oen_o, .address_hold_enable_i, .data_hold_enable_i,
  .own_address_we_i, .irq_clear_i, .buffer_read_i, .overflow_clear_i,
  .clock_release_set_i, .serial_port_irq_flag_o, .buffer_full_flag_o,
  .receive_overflow_flag_o, .ack_phase_flag_o,
  .low_byte_pending_flag_o, .clock_release_bit_o
);

//--- isar_bus_master.sv
`timescale 1ns/10ps
module isar_bus_master (
  output logic      scl_m_o,
  output logic      sda_m_o,
  input  wire logic scl_line_i,
  input  wire logic sda_line_i
);
  // ------
  // Bus master, 64 ns ticks
  // ------
  localparam int TQ = 64;
  initial begin
    scl_m_o = 1'b1;
    sda_m_o = 1'b1;
  end
  task automatic start_c;
    sda_m_o = 1'b1;
    #TQ scl_m_o = 1'b1;
    wait (scl_line_i);
    #(2*TQ) sda_m_o = 1'b0;
    #(2*TQ) scl_m_o = 1'b0;
    #(2*TQ);
  endtask : start_c
  task automatic stop_c;
    #TQ sda_m_o = 1'b0;
    #TQ scl_m_o = 1'b1;
    wait (scl_line_i);
    #(2*TQ) sda_m_o = 1'b1;
    #(4*TQ);
  endtask : stop_c
  // data set in low phase, stretch honoured
  task automatic bit_x(input logic b, output logic r);
    #TQ sda_m_o = b;
    #(3*TQ) scl_m_o = 1'b1;
    wait (scl_line_i);
    r = sda_line_i;
    #(2*TQ) scl_m_o = 1'b0;
  endtask : bit_x
  // msb first, line released in slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
    #(4*TQ);
  endtask : wr_byte
endmodule : isar_bus_master

//--- tb.sv
`timescale 1ns/10ps
module tb;
  // ------
  // Bench
  // ------
  logic       clk_sys_i, nrst_i, scl_m, sda_m, scl_line, sda_line;
  logic [3:0] mode;
  logic       address_hold_enable, data_hold_enable, stretch_enable, ackv, crel, we, irqc, bufrd, ovfc, ssie;
  logic       spie, scl_o, scl_oen, sda_o, sda_oen, irq, full, ovf, rxack;
  logic       ackph, pend, rdir, sseen, pseen, crb;
  logic [7:0] own_wd, rbuf, own_q;
  int         n_fail, total_checks;

  assign scl_line = scl_m & (scl_oen | scl_o);
  assign sda_line = sda_m & (sda_oen | sda_o);

  isar_slave_rx dut_u (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_clk_i(scl_line),
    .sda_i(sda_line), .scl_o(scl_o), .scl_oen_o(scl_oen),
    .sda_o(sda_o), .sda_oen_o(sda_oen), .port_mode_select_i(mode),
    .start_irq_enable_i(ssie), .stop_irq_enable_i(spie),
    .address_hold_enable_i(address_hold_enable), .data_hold_enable_i(data_hold_enable),
    .stretch_enable_i(stretch_enable), .ack_value_select_i(ackv),
    .clock_release_set_i(crel), .own_address_wdata_i(own_wd),
    .own_address_we_i(we), .irq_clear_i(irqc), .buffer_read_i(bufrd),
    .overflow_clear_i(ovfc), .rx_tx_buffer_o(rbuf),
    .own_address_reg_o(own_q), .serial_port_irq_flag_o(irq),
    .buffer_full_flag_o(full), .receive_overflow_flag_o(ovf),
    .received_ack_flag_o(rxack), .ack_phase_flag_o(ackph),
    .low_byte_pending_flag_o(pend), .read_dir_flag_o(rdir),
    .start_seen_flag_o(sseen), .stop_seen_flag_o(pseen),
    .clock_release_bit_o(crb)
  );
  isar_bus_master m_u (.scl_m_o(scl_m), .sda_m_o(sda_m),
    .scl_line_i(scl_line), .sda_line_i(sda_line));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys_i) {crel, ovfc, bufrd, irqc} <= m;
    @(posedge clk_sys_i) {crel, ovfc, bufrd, irqc} <= 4'h0;
    @(posedge clk_sys_i) #1;
  endtask : pulse

  task automatic own_wr(input logic [7:0] d);
    @(posedge clk_sys_i);
    own_wd <= d;
    we     <= 1'b1;
    @(posedge clk_sys_i) we <= 1'b0;
    @(posedge clk_sys_i) #1;
  endtask : own_wr

  task automatic t_modes;
    logic [3:0] md [4];
    md = '{isar_pkg::MODE_7B, isar_pkg::MODE_10B,
           isar_pkg::MODE_7B_SS, isar_pkg::MODE_10B_SS};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i);
      mode <= md[i/2];
      ssie <= i[0];
      spie <= i[0];
      pulse(4'h1);
      m_u.start_c();
      chk(sseen, 1'b1);
      chk(irq, i >= 4 || i[0]);
      pulse(4'h1);
      m_u.stop_c();
      chk(pseen, 1'b1);
      chk(irq, i >= 4 || i[0]);
    end
  endtask : t_modes

  task automatic t_rx7;
    logic a;
    @(posedge clk_sys_i);
    mode <= isar_pkg::MODE_7B;
    ssie <= 1'b0;
    spie <= 1'b0;
    own_wr(8'h54);
    pulse(4'h1);
    m_u.start_c();
    m_u.wr_byte(8'h56, a);
    chk({a, irq, full}, 16'h4);
    m_u.start_c();
    m_u.wr_byte(8'h54, a);
    chk({a, rxack, rdir, full, irq}, 16'h3);
    chk(rbuf, 16'h54);
    pulse(4'h3);
    chk({full, irq}, 16'h0);
    @(posedge clk_sys_i) stretch_enable <= 1'b1;
    m_u.wr_byte(8'hc5, a);
    chk({a, rbuf}, 16'h0c5);
    chk({crb, scl_oen}, 16'h0);
    pulse(4'h8);
    chk({crb, scl_oen}, 16'h3);
    @(posedge clk_sys_i) stretch_enable <= 1'b0;
    m_u.wr_byte(8'h3a, a);
    chk({a, ovf, rbuf}, 16'h3c5);
    m_u.stop_c();
    pulse(4'h7);
    chk({full, ovf}, 16'h0);
    m_u.start_c();
    m_u.wr_byte(8'h55, a);
    chk({a, rdir}, 16'h1);
    m_u.stop_c();
  endtask : t_rx7

  task automatic t_hold;
    logic a;
    @(posedge clk_sys_i);
    address_hold_enable <= 1'b1;
    data_hold_enable <= 1'b1;
    ackv <= 1'b1;
    pulse(4'h7);
    m_u.start_c();
    fork
      m_u.wr_byte(8'h54, a);
      begin
        repeat (300) if (!ackph) @(posedge clk_sys_i);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({ackph, scl_oen}, 16'h2);
        pulse(4'h8);
      end
    join
    chk({a, rxack, ackph}, 16'h6);
    m_u.stop_c();
    @(posedge clk_sys_i);
    address_hold_enable <= 1'b0;
    data_hold_enable <= 1'b0;
  endtask : t_hold

  task automatic t_ten;
    logic a;
    @(posedge clk_sys_i) mode <= isar_pkg::MODE_10B;
    own_wr(8'h04);
    pulse(4'h7);
    m_u.start_c();
    m_u.wr_byte(8'hf2, a);
    chk({a, pend}, 16'h2);
    m_u.start_c();
    fork
      begin
        m_u.wr_byte(8'hf4, a);
        chk(a, 1'b0);
        m_u.wr_byte(8'h3b, a);
      end
      begin
        repeat (400) if (!pend) @(posedge clk_sys_i);
        own_wr(8'h3b);
        chk({pend, own_q}, 16'h3b);
        pulse(4'h3);
        repeat (900) if (!pend) @(posedge clk_sys_i);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({irq, scl_oen}, 16'h2);
        own_wr(8'h04);
        chk(pend, 1'b0);
        pulse(4'h2);
      end
    join
    m_u.start_c();
    m_u.wr_byte(8'hf5, a);
    chk({a, rdir}, 16'h1);
    m_u.stop_c();
  endtask : t_ten

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    nrst_i = 1'b0;
    mode = 4'h0;
    own_wd = 8'h00;
    {address_hold_enable, data_hold_enable, stretch_enable, ackv, crel, we, irqc, bufrd, ovfc, ssie, spie} = '0;
    n_fail = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i) #1;
    chk({scl_oen, sda_oen, crb, rbuf}, 16'h700);
    chk({irq, full, ovf, rxack, ackph, pend, rdir, sseen, pseen}, 16'h0);
    chk(own_q, 16'h0);
    repeat (4) @(posedge clk_sys_i);
    t_modes();
    t_rx7();
    t_hold();
    t_ten();
    end_sim();
  end

  initial begin
    #1000000;
    n_fail++;
    end_sim();
  end
endmodule : tb
